// File: design/cca_map.svh
// Register offsets, field positions, reset values and timing counts of the channel assessment unit
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCA_OFS_STATUS      6'h01
`define CCA_OFS_CONTROL     6'h08
`define CCA_OFS_THRESHOLD   6'h09
`define CCA_OFS_SYNC        6'h15
`define CCA_OFS_STATE       6'h3e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCA_BIT_COMPLETE    7
`define CCA_BIT_IDLE        6
`define CCA_BIT_REQUEST     7
`define ASSESSMENT_MODE_FIELD_HI         6
`define ASSESSMENT_MODE_FIELD_LO         5
`define CCA_THR_HI          3
`define CCA_THR_LO          0
`define CCA_BIT_PDT_DIS     7
`define CCA_BIT_EXT_MODE    0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCA_RST_CONTROL     8'h2b
`define CCA_RST_THRESHOLD   8'h07
`define CCA_RST_SYNC        8'h00
`define CCA_RST_STATE       8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCA_CLK_MHZ         100
`define CCA_SYMBOL_NS       16000
`define CCA_SYMBOL_CYCLES   ((`CCA_SYMBOL_NS * `CCA_CLK_MHZ + 999) / 1000)
`define CCA_MEAS_SYMBOLS    8
`define CCA_AUTO_SYM_STD    8
`define CCA_AUTO_SYM_HR     2
`define CCA_PROC_NS         1000
`define CCA_PROC_CYCLES     ((`CCA_PROC_NS * `CCA_CLK_MHZ + 999) / 1000)

`endif

// File: design/cca_pkg.sv
// Types shared by the channel assessment unit
package cca_pkg;

  // Assessment modes as held in the mode field
  typedef enum logic [1:0] {
    ASSESSMENT_MODE_FIELD_OR     = 2'h0,
    ASSESSMENT_MODE_FIELD_ENERGY = 2'h1,
    ASSESSMENT_MODE_FIELD_CARRIER = 2'h2,
    ASSESSMENT_MODE_FIELD_AND    = 2'h3
  } assessment_mode_field_type;

  // Receiver state as reported by the radio
  typedef enum logic [4:0] {
    CCA_TRX_OFF     = 5'h08,
    CCA_TRX_RX_ON   = 5'h06,
    CCA_TRX_BUSY_RX = 5'h01,
    CCA_TRX_OTHER   = 5'h00
  } cca_trx_type;

  // Assessment sequencer
  typedef enum logic [2:0] {
    CCA_IDLE,
    CCA_MEASURE,
    CCA_PROCESS,
    CCA_WAIT_AUTO,
    CCA_FINISH
  } cca_fsm_type;

  // Register bus request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cca_bus_type;

  // Radio front end indications
  typedef struct packed {
    logic [7:0] energy_level;
    logic       carrier_detect;
    logic       sync_header;
    logic       frame_end;
  } cca_radio_type;

endpackage

// File: design/cca_unit.sv
// Clear channel assessment unit with its register file
`include "cca_map.svh"

module cca_unit
  import cca_pkg::*;
#(
  parameter int SYMBOL_CYCLES = `CCA_SYMBOL_CYCLES,
  parameter int PROC_CYCLES   = `CCA_PROC_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire cca_bus_type   bus,
  output logic [7:0]         rdata,
  input  wire cca_radio_type radio,
  input  wire logic          rx_listen,
  input  wire logic          high_rate,
  output logic               measurement_done_event,
  output logic               preamble_detect_disable,
  output logic [4:0]         trx_state_out
);

  localparam int CW = $clog2(SYMBOL_CYCLES * `CCA_MEAS_SYMBOLS + PROC_CYCLES + 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cca_fsm_type   fsm;
    logic [CW-1:0] cnt;
    logic [CW-1:0] auto_cnt;
    logic          auto_run;
    logic          auto_used;
    logic          busy_seen;
    logic          complete;
    logic          idle;
    assessment_mode_field_type  mode;
    logic [3:0]    thr;
    logic [4:0]    channel;
    logic [7:0]    sync_reg;
    logic          ext_mode;
    logic          rx_busy;
    logic [4:0]    trx;
    logic [7:0]    rdata;
    logic          done;
  } cca_state_type;

  cca_state_type s_q;
  cca_state_type s_d;

  // Energy test against threshold: base + 2 dB * thr, energy in 1 dB steps
  function automatic logic energy_busy(input logic [7:0] lvl, input logic [3:0] t);
    energy_busy = lvl > {3'h0, t, 1'b0};
  endfunction

  // Mode combination of carrier and energy
  function automatic logic chan_busy(input assessment_mode_field_type m, input logic cs, input logic ed);
    case (m)
      ASSESSMENT_MODE_FIELD_OR:      chan_busy = cs | ed;
      ASSESSMENT_MODE_FIELD_ENERGY:  chan_busy = ed;
      ASSESSMENT_MODE_FIELD_CARRIER: chan_busy = cs;
      default:          chan_busy = cs & ed;
    endcase
  endfunction

  // Window lengths derived from symbol count
  function automatic logic [CW-1:0] sym_cycles(input int n);
    sym_cycles = CW'(SYMBOL_CYCLES * n);
  endfunction

  logic busy_now;
  logic listen_ok;
  logic request;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.rdata = 8'h00;
    busy_now  = chan_busy(s_q.mode, radio.carrier_detect, energy_busy(radio.energy_level, s_q.thr));
    listen_ok = rx_listen & ~s_q.ext_mode;
    request   = bus.wr && (bus.addr == `CCA_OFS_CONTROL) && bus.wdata[`CCA_BIT_REQUEST];

    // Receiver enters busy state on a sync header unless detection is off
    if (!rx_listen || radio.frame_end) begin
      s_d.rx_busy   = 1'b0;
      s_d.auto_used = 1'b0;
    end else if (radio.sync_header && !s_q.sync_reg[`CCA_BIT_PDT_DIS] && !s_q.rx_busy) begin
      s_d.rx_busy = 1'b1;
    end

    // One automatic energy measurement per frame
    if (radio.sync_header && s_d.rx_busy && !s_q.auto_used && !s_q.rx_busy) begin
      s_d.auto_run  = 1'b1;
      s_d.auto_used = 1'b1;
      s_d.auto_cnt  = high_rate ? sym_cycles(`CCA_AUTO_SYM_HR) : sym_cycles(`CCA_AUTO_SYM_STD);
    end else if (s_q.auto_run) begin
      if (s_q.auto_cnt <= CW'(1)) begin
        s_d.auto_run = 1'b0;
      end
      s_d.auto_cnt = s_q.auto_cnt - CW'(1);
    end

    // Register writes
    if (bus.wr) begin
      if (bus.addr == `CCA_OFS_CONTROL) begin
        s_d.mode    = assessment_mode_field_type'(bus.wdata[`ASSESSMENT_MODE_FIELD_HI:`ASSESSMENT_MODE_FIELD_LO]);
        s_d.channel = bus.wdata[4:0];
      end else if (bus.addr == `CCA_OFS_THRESHOLD) begin
        s_d.thr = bus.wdata[`CCA_THR_HI:`CCA_THR_LO];
      end else if (bus.addr == `CCA_OFS_SYNC) begin
        s_d.sync_reg = bus.wdata;
      end else if (bus.addr == `CCA_OFS_STATE) begin
        s_d.ext_mode = bus.wdata[`CCA_BIT_EXT_MODE];
      end
    end

    // Assessment sequencer
    case (s_q.fsm)
      CCA_IDLE: begin
        if (request) begin
          s_d.complete  = 1'b0;
          s_d.idle      = 1'b0;
          s_d.busy_seen = 1'b0;
          if (!listen_ok) begin
            s_d.fsm = CCA_FINISH;
          end else if (!s_q.rx_busy) begin
            s_d.fsm = CCA_MEASURE;
            s_d.cnt = sym_cycles(`CCA_MEAS_SYMBOLS);
          end else if (s_d.mode == ASSESSMENT_MODE_FIELD_CARRIER || !s_q.auto_run) begin
            s_d.fsm       = CCA_FINISH;
            // Judge with the mode written by this very request
            s_d.busy_seen = chan_busy(s_d.mode, radio.carrier_detect,
                                      energy_busy(radio.energy_level, s_q.thr));
          end else begin
            s_d.fsm = CCA_WAIT_AUTO;
          end
        end
      end
      CCA_MEASURE: begin
        s_d.busy_seen = s_q.busy_seen | busy_now;
        s_d.cnt       = s_q.cnt - CW'(1);
        if (s_q.cnt <= CW'(1)) begin
          s_d.fsm = CCA_PROCESS;
          s_d.cnt = CW'(PROC_CYCLES);
        end
      end
      CCA_PROCESS: begin
        s_d.cnt = s_q.cnt - CW'(1);
        if (s_q.cnt <= CW'(1)) begin
          s_d.fsm = CCA_FINISH;
        end
      end
      CCA_WAIT_AUTO: begin
        s_d.busy_seen = s_q.busy_seen | busy_now;
        if (!s_q.auto_run) begin
          s_d.fsm = CCA_FINISH;
        end
      end
      default: begin
        s_d.complete = 1'b1;
        s_d.idle     = listen_ok & ~s_q.busy_seen;
        s_d.done     = 1'b1;
        s_d.fsm      = CCA_IDLE;
      end
    endcase

    // Registered receiver state, shared by status read and state output
    s_d.trx = trx_code(s_d.rx_busy);

    // Register reads, data valid the next cycle
    if (bus.rd) begin
      if (bus.addr == `CCA_OFS_STATUS) begin
        s_d.rdata = {s_q.complete, s_q.idle, 1'b0, s_q.trx};
      end else if (bus.addr == `CCA_OFS_CONTROL) begin
        s_d.rdata = {1'b0, s_q.mode, s_q.channel};
      end else if (bus.addr == `CCA_OFS_THRESHOLD) begin
        s_d.rdata = {4'h0, s_q.thr};
      end else if (bus.addr == `CCA_OFS_SYNC) begin
        s_d.rdata = s_q.sync_reg;
      end else if (bus.addr == `CCA_OFS_STATE) begin
        s_d.rdata = {7'h00, s_q.ext_mode};
      end else begin
        s_d.rdata = 8'h00;
      end
    end
  end

  // Receiver state code for the status register
  function automatic logic [4:0] trx_code(input logic busy);
    if (!rx_listen) begin
      trx_code = CCA_TRX_OFF;
    end else if (busy) begin
      trx_code = CCA_TRX_BUSY_RX;
    end else begin
      trx_code = CCA_TRX_RX_ON;
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.fsm      <= CCA_IDLE;
      s_q.mode     <= assessment_mode_field_type'(2'(`CCA_RST_CONTROL >> `ASSESSMENT_MODE_FIELD_LO));
      s_q.trx      <= CCA_TRX_RX_ON;
      s_q.channel  <= 5'(`CCA_RST_CONTROL);
      s_q.thr      <= 4'(`CCA_RST_THRESHOLD);
      s_q.sync_reg <= `CCA_RST_SYNC;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata                   = s_q.rdata;
  assign measurement_done_event  = s_q.done;
  assign preamble_detect_disable = s_q.sync_reg[`CCA_BIT_PDT_DIS];
  assign trx_state_out           = s_q.trx;

endmodule

// File: verif/cca_properties.sv
// Port checker of the channel assessment unit
module cca_properties
  import cca_pkg::*;
#(
  parameter int SYMBOL_CYCLES = 4,
  parameter int PROC_CYCLES   = 2
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire cca_bus_type   bus,
  input wire logic [7:0]    rdata,
  input wire cca_radio_type radio,
  input wire logic          rx_listen,
  input wire logic          high_rate,
  input wire logic          measurement_done_event,
  input wire logic          preamble_detect_disable,
  input wire logic [4:0]    trx_state_out
);
  localparam int LISTEN_TAIL = 8 * SYMBOL_CYCLES + PROC_CYCLES - 5;
  logic req;
  logic run_q;

  // Request write and assessment in flight
  assign req = bus.wr && bus.addr == 6'h08 && bus.wdata[7];
  always_ff @(posedge clk) begin
    if (rst) run_q <= 1'b0;
    else if (measurement_done_event) run_q <= 1'b0;
    else if (req) run_q <= 1'b1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_listen_start;
    req && !run_q && rx_listen && preamble_detect_disable && trx_state_out == 5'h06;
  endsequence
  sequence s_status_read;
    bus.rd && bus.addr == 6'h01;
  endsequence

  property p_listen_time;
    s_listen_start |-> (!measurement_done_event)[*8] ##LISTEN_TAIL measurement_done_event;
  endproperty
  a_listen_time: assert property (p_listen_time) else $error("listen assessment time wrong");
  property p_clear_flags;
    s_listen_start ##1 s_status_read |=> rdata[7:6] == 2'b00;
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared by request");
  property p_out_of_state;
    req && !run_q && !rx_listen |-> ##2 measurement_done_event;
  endproperty
  a_out_of_state: assert property (p_out_of_state) else $error("no done outside receive");
  property p_carrier_busy;
    req && !run_q && trx_state_out == 5'h01 && bus.wdata[6:5] == 2'h2 |-> ##2 measurement_done_event;
  endproperty
  a_carrier_busy: assert property (p_carrier_busy) else $error("carrier mode not immediate");
  property p_done_pulse;
    measurement_done_event |=> !measurement_done_event;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_done_cause;
    measurement_done_event |-> run_q;
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without request");
  property p_request_reads_zero;
    bus.rd && bus.addr == 6'h08 |=> !rdata[7];
  endproperty
  a_request_reads_zero: assert property (p_request_reads_zero) else $error("request bit read one");
  property p_rdata_quiet;
    !bus.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data without read");
  property p_pdt_holds_listen;
    preamble_detect_disable && rx_listen && trx_state_out == 5'h06 |=> trx_state_out == 5'h06;
  endproperty
  a_pdt_holds_listen: assert property (p_pdt_holds_listen) else $error("left listen state");
  property p_status_state;
    s_status_read |=> rdata[4:0] == $past(trx_state_out) && !rdata[5];
  endproperty
  a_status_state: assert property (p_status_state) else $error("status state field wrong");
endmodule

bind cca_unit cca_properties #(.SYMBOL_CYCLES(SYMBOL_CYCLES), .PROC_CYCLES(PROC_CYCLES)) u_props (
  .clk, .rst, .bus, .rdata, .radio, .rx_listen, .high_rate, .measurement_done_event,
  .preamble_detect_disable, .trx_state_out);

// File: verif/tb.sv
// Self-checking bench of the channel assessment unit
module tb
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LDONE = 8 * 4 + 2 + 2;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  cca_bus_type   bus = '0;
  cca_radio_type radio = '0;
  logic          rx_listen = 1'b1;
  logic          high_rate = 1'b0;
  logic [7:0]    rdata;
  logic          done;
  logic          pdt;
  logic [4:0]    trx;
  int            err_count = 0;
  int            check_count = 0;
  int            seed = 32'h68fe;
  int            k;
  logic [31:0]   r;
  logic [7:0]    rv;
  logic [7:0]    e;
  logic [3:0]    t;
  logic [5:0]    ra[5] = '{6'h08, 6'h09, 6'h15, 6'h01, 6'h3f};
  logic [7:0]    rx[5] = '{8'h2b, 8'h07, 8'h00, 8'h06, 8'h00};

  cca_unit #(.SYMBOL_CYCLES(4), .PROC_CYCLES(2)) uut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .radio(radio), .rx_listen(rx_listen), .high_rate(high_rate), .measurement_done_event(done),
    .preamble_detect_disable(pdt), .trx_state_out(trx));

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  initial forever #5 clk = ~clk;
  task automatic wr(logic [5:0] a, logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(logic s);
    radio.sync_header <= s;
    radio.frame_end <= !s;
    @(posedge clk);
    radio.sync_header <= 1'b0;
    radio.frame_end <= 1'b0;
  endtask
  task automatic wait_done(inout int n);
    #1;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    n++; // Count the edge at which done is sampled
    @(posedge clk);
  endtask
  // Request, wait for done, check flags and control readback
  task automatic assess(logic [1:0] m, logic idle, logic early, output int n);
    n = 0;
    wr(6'h08, {1'b1, m, 5'h0b});
    if (early) begin
      rd(6'h01, rv);
      chk({6'h00, rv[7:6]}, 8'h00);
      n = 2;
    end
    wait_done(n);
    rd(6'h01, rv);
    chk({rv[7:6], 6'h00}, {1'b1, idle, 6'h00});
    rd(6'h08, rv);
    chk(rv, {1'b0, m, 5'h0b});
  endtask
  function automatic logic idle_exp(logic [1:0] m, logic [7:0] en, logic [3:0] th, logic c);
    logic hi;
    hi = en > {3'h0, th, 1'b0};
    case (m)
      2'h0: return !(hi || c);
      2'h1: return !hi;
      2'h2: return !c;
      default: return !(hi && c);
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(6'h01, 8'hff);
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, rx[i]);
    end
    $display("test reset values done");
    wr(6'h15, 8'h80);
    pulse(1'b1);
    rd(6'h01, rv);
    chk(rv, 8'h06);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      t = r[3:0];
      e = (i < 4) ? {3'h0, t, 1'b0} : {3'h0, r[8:4]};
      radio.energy_level <= e;
      radio.carrier_detect <= r[9];
      wr(6'h09, {4'h0, t});
      @(posedge clk);
      assess(2'(i), idle_exp(2'(i), e, t, r[9]), 1'b1, k);
      chk(8'(k), 8'(LDONE));
    end
    $display("test listen modes done");
    rx_listen <= 1'b0;
    assess(2'h1, 1'b0, 1'b0, k);
    chk(8'(k), 8'h02);
    rx_listen <= 1'b1;
    $display("test out of state done");
    radio.energy_level <= 8'h40;
    radio.carrier_detect <= 1'b0;
    wr(6'h15, 8'h00);
    pulse(1'b1);
    rd(6'h01, rv);
    chk({3'h0, rv[4:0]}, 8'h01);
    assess(2'h2, 1'b1, 1'b0, k);
    chk(8'(k), 8'h02);
    repeat (40) @(posedge clk);
    assess(2'h1, 1'b0, 1'b0, k);
    chk(8'(k), 8'h02);
    pulse(1'b0);
    high_rate <= 1'b1;
    pulse(1'b1);
    assess(2'h0, 1'b0, 1'b0, k);
    chk(8'(k > 2 && k < 20), 8'h01);
    pulse(1'b0);
    $display("test busy receive done");
    wr(6'h3e, 8'h01);
    assess(2'h1, 1'b0, 1'b0, k);
    chk(8'(k), 8'h02);
    wr(6'h3e, 8'h00);
    $display("test extended mode done");
    tally_and_finish();
  end
  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule
